// *** rtl/fieldbus_terminal_bus_diagnostics.sv ***
// Purpose: Fieldbus start-up state code, terminal-bus state word and indicators.
// Assumes: Event and status inputs come from logic on core_clk_in.
// Notes:   Remote read answers one cycle after the request.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Fieldbus state code: 0 ok, 129 await config, 130 await params, 131 no master.
// - Interrupted master link forces state code 130, awaiting parameter data.
// - Start-up order: parameters, then configuration, then data exchange.
// - State code read as one byte at group 0006, offset 000C_A080.
// - Terminal-bus word: zero ok, bit 0 error, bit 2 re-trigger notice.
// - Terminal-bus word read as one byte at group 0006, offset 000C_9000.
// - RUN indicator off without updates, on or flashing while cycling.
// - ERR indicator off without error or with code 0, flashes current error code otherwise.
// - Code 1 argument: 0 checksum, 1 code overflow, 2 unknown data type.
// - Terminal-bus command failure gives code 3, argument 0.
// - Data error with break behind controller gives code 4, argument 0.
// - Code 0 means EMC trouble; reserved code 2 never emitted.
// - Cycle overrun flashes code 7 argument 0 until reset.
module fieldbus_terminal_bus_diagnostics
  import diag_pkg::*;
#(
  parameter int FLASH_HALF = FLASH_HALF_CYC,
  parameter int RUN_HALF   = RUN_HALF_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  // Fieldbus link events
  input  wire logic        master_present_in,
  input  wire logic        link_lost_in,
  input  wire logic        prm_accepted_in,
  input  wire logic        cfg_accepted_in,
  // Terminal-bus status
  input  wire logic        tb_cycling_in,
  input  wire logic        tb_retrig_in,
  input  wire logic        tb_ack_in,
  input  wire tb_faults_s  tb_faults_in,
  // Remote read service
  input  wire read_req_s   rd_req_in,
  output logic             rd_valid_out,
  output logic [7:0]       rd_data_out,
  // State outputs
  output logic [7:0]       fieldbus_state_code_out,
  output logic [7:0]       tb_state_out,
  // Indicators
  output logic             tb_run_indicator_out,
  output logic             terminal_bus_error_indicator_out
);

  // ****************************************
  // Start-up state
  // ****************************************
  startup_e   su_reg, su_next;
  logic [7:0] fb_code_reg, fb_code_next;

  always_comb begin
    su_next = su_reg;
    if (link_lost_in || !master_present_in) begin
      su_next = SU_WAIT_PRM;
    end else begin
      unique case (su_reg)
        SU_WAIT_PRM: if (prm_accepted_in) su_next = SU_WAIT_CFG;
        SU_WAIT_CFG: if (cfg_accepted_in) su_next = SU_DATA_EX;
        SU_DATA_EX:  su_next = SU_DATA_EX;
        default:     su_next = SU_WAIT_PRM;
      endcase
    end
    if (!master_present_in) begin
      fb_code_next = FB_NO_MASTER;
    end else if (link_lost_in) begin
      fb_code_next = FB_WAIT_PRM;
    end else begin
      unique case (su_next)
        SU_WAIT_PRM: fb_code_next = FB_WAIT_PRM;
        SU_WAIT_CFG: fb_code_next = FB_WAIT_CFG;
        SU_DATA_EX:  fb_code_next = FB_OK;
        default:     fb_code_next = FB_WAIT_PRM;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      su_reg      <= SU_WAIT_PRM;
      fb_code_reg <= FB_NO_MASTER;
    end else begin
      su_reg      <= su_next;
      fb_code_reg <= fb_code_next;
    end
  end

  // ****************************************
  // Terminal-bus state and error selection
  // ****************************************
  logic       tb_err_reg, tb_err_next;
  logic       tb_rt_reg, tb_rt_next;
  logic       overrun_reg, overrun_next;
  logic       any_err;
  logic [3:0] code_sel;
  logic [3:0] arg_sel;

  always_comb begin
    overrun_next = overrun_reg | tb_faults_in.cycle_overrun;
    tb_rt_next   = tb_retrig_in | (tb_rt_reg & ~tb_ack_in);
    code_sel     = EC_EMC;
    arg_sel      = ARG_ZERO;
    any_err      = 1'b1;
    if (overrun_next) begin
      code_sel = EC_CYCLE;
    end else if (tb_faults_in.chksum_fail) begin
      code_sel = EC_CONFIG;
      arg_sel  = ARG_CHKSUM;
    end else if (tb_faults_in.code_overflow) begin
      code_sel = EC_CONFIG;
      arg_sel  = ARG_OVERFLOW;
    end else if (tb_faults_in.unknown_dtype) begin
      code_sel = EC_CONFIG;
      arg_sel  = ARG_DTYPE;
    end else if (tb_faults_in.cmd_fail) begin
      code_sel = EC_COMMAND;
    end else if (tb_faults_in.data_break) begin
      code_sel = EC_DATA;
    end else if (tb_faults_in.emc_fault) begin
      code_sel = EC_EMC;
    end else begin
      any_err = 1'b0;
    end
    tb_err_next = any_err;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tb_err_reg  <= 1'b0;
      tb_rt_reg   <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      tb_err_reg  <= tb_err_next;
      tb_rt_reg   <= tb_rt_next;
      overrun_reg <= overrun_next;
    end
  end

  logic [7:0] tb_word;
  always_comb begin
    tb_word               = 8'h00;
    tb_word[TB_BIT_ERROR]  = tb_err_reg;
    tb_word[TB_BIT_RETRIG] = tb_rt_reg;
  end

  // ****************************************
  // Remote read service
  // ****************************************
  logic       rd_valid_reg, rd_valid_next;
  logic [7:0] rd_data_reg, rd_data_next;

  always_comb begin
    rd_valid_next = rd_req_in.req;
    rd_data_next  = rd_data_reg;
    if (rd_req_in.req) begin
      rd_data_next = RD_UNMAPPED;
      if (rd_req_in.index_group == RD_INDEX_GROUP) begin
        if (rd_req_in.index_offset == RD_OFS_FB_STATE) begin
          rd_data_next = fb_code_reg;
        end else if (rd_req_in.index_offset == RD_OFS_TB_STATE) begin
          rd_data_next = tb_word;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= 8'h00;
    end else begin
      rd_valid_reg <= rd_valid_next;
      rd_data_reg  <= rd_data_next;
    end
  end

  // ****************************************
  // RUN indicator
  // ****************************************
  logic [31:0] run_cnt_reg, run_cnt_next;
  logic        run_reg, run_next;

  always_comb begin
    run_cnt_next = run_cnt_reg;
    run_next     = 1'b0;
    if (tb_cycling_in) begin
      if (tb_err_reg) begin
        run_next = run_reg;
        if (run_cnt_reg >= 32'(RUN_HALF - 1)) begin
          run_cnt_next = 32'h0;
          run_next     = ~run_reg;
        end else begin
          run_cnt_next = run_cnt_reg + 32'h1;
        end
      end else begin
        run_next     = 1'b1;
        run_cnt_next = 32'h0;
      end
    end else begin
      run_cnt_next = 32'h0;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_cnt_reg <= 32'h0;
      run_reg     <= 1'b0;
    end else begin
      run_cnt_reg <= run_cnt_next;
      run_reg     <= run_next;
    end
  end

  // ****************************************
  // ERR flash sequencer
  // ****************************************
  flash_e      fl_reg, fl_next;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic [4:0]  half_reg, half_next;
  logic [3:0]  code_reg, code_next;
  logic [3:0]  arg_reg, arg_next;
  logic        err_led_reg, err_led_next;
  logic        tick;
  logic [4:0]  burst_len;

  assign tick = (tick_cnt_reg >= 32'(FLASH_HALF - 1));

  always_comb begin
    fl_next       = fl_reg;
    half_next     = half_reg;
    code_next     = code_reg;
    arg_next      = arg_reg;
    err_led_next  = err_led_reg;
    tick_cnt_next = tick ? 32'h0 : tick_cnt_reg + 32'h1;
    burst_len     = (fl_reg == FL_CODE) ? {code_reg, 1'b0} : {arg_reg, 1'b0};
    if (!tb_err_reg) begin
      fl_next       = FL_IDLE;
      err_led_next  = 1'b0;
      tick_cnt_next = 32'h0;
      half_next     = 5'h0;
    end else if (fl_reg == FL_IDLE) begin
      fl_next      = FL_GAP;
      code_next    = code_sel;
      arg_next     = arg_sel;
      half_next    = 5'h0;
      err_led_next = 1'b0;
    end else if (tick) begin
      unique case (fl_reg)
        FL_CODE, FL_ARG: begin
          if (half_reg + 5'h1 >= burst_len) begin
            half_next    = 5'h0;
            err_led_next = 1'b0;
            fl_next      = (fl_reg == FL_CODE) ? FL_PAUSE : FL_GAP;
          end else begin
            half_next    = half_reg + 5'h1;
            err_led_next = ~err_led_reg;
          end
        end
        FL_PAUSE, FL_GAP: begin
          if (half_reg + 5'h1 >= 5'(PAUSE_HALVES)) begin
            half_next = 5'h0;
            if (fl_reg == FL_GAP) begin
              code_next = code_sel;
              arg_next  = arg_sel;
            end
            fl_next      = (fl_reg == FL_GAP) ? FL_CODE : FL_ARG;
            err_led_next = 1'b1;
            if (((fl_reg == FL_GAP) ? code_sel : arg_reg) == 4'h0) begin
              fl_next      = (fl_reg == FL_GAP) ? FL_PAUSE : FL_GAP;
              err_led_next = 1'b0;
            end
          end else begin
            half_next = half_reg + 5'h1;
          end
        end
        default: fl_next = FL_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fl_reg       <= FL_IDLE;
      tick_cnt_reg <= 32'h0;
      half_reg     <= 5'h0;
      code_reg     <= 4'h0;
      arg_reg      <= 4'h0;
      err_led_reg  <= 1'b0;
    end else begin
      fl_reg       <= fl_next;
      tick_cnt_reg <= tick_cnt_next;
      half_reg     <= half_next;
      code_reg     <= code_next;
      arg_reg      <= arg_next;
      err_led_reg  <= err_led_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic [7:0] tb_out_reg;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tb_out_reg <= 8'h00;
    end else begin
      tb_out_reg <= tb_word;
    end
  end

  assign rd_valid_out                     = rd_valid_reg;
  assign rd_data_out                      = rd_data_reg;
  assign fieldbus_state_code_out          = fb_code_reg;
  assign tb_state_out                     = tb_out_reg;
  assign tb_run_indicator_out             = run_reg;
  assign terminal_bus_error_indicator_out = err_led_reg;

endmodule
`default_nettype wire

// *** rtl/diag_pkg.sv ***
// Purpose: Shared constants and types for the fieldbus and terminal-bus diagnostics.
// Assumes: 250 MHz core clock.
// Notes:   Index values are those of the remote read service.
`default_nettype none
package diag_pkg;

  // ****************************************
  // Fieldbus state codes
  // ****************************************
  localparam logic [7:0] FB_OK        = 8'h00;
  localparam logic [7:0] FB_WAIT_CFG  = 8'h81;
  localparam logic [7:0] FB_WAIT_PRM  = 8'h82;
  localparam logic [7:0] FB_NO_MASTER = 8'h83;

  // ****************************************
  // Remote read index values
  // ****************************************
  localparam logic [15:0] RD_INDEX_GROUP    = 16'h0006;
  localparam logic [31:0] RD_OFS_FB_STATE   = 32'h000c_a080;
  localparam logic [31:0] RD_OFS_TB_STATE   = 32'h000c_9000;
  localparam logic [7:0]  RD_UNMAPPED       = 8'h00;

  // ****************************************
  // Terminal-bus state word fields
  // ****************************************
  localparam int TB_BIT_ERROR   = 0;
  localparam int TB_BIT_RETRIG  = 2;

  // ****************************************
  // Error codes and arguments
  // ****************************************
  localparam logic [3:0] EC_EMC       = 4'h0;
  localparam logic [3:0] EC_CONFIG    = 4'h1;
  localparam logic [3:0] EC_COMMAND   = 4'h3;
  localparam logic [3:0] EC_DATA      = 4'h4;
  localparam logic [3:0] EC_CYCLE     = 4'h7;
  localparam logic [3:0] ARG_CHKSUM   = 4'h0;
  localparam logic [3:0] ARG_OVERFLOW = 4'h1;
  localparam logic [3:0] ARG_DTYPE    = 4'h2;
  localparam logic [3:0] ARG_ZERO     = 4'h0;

  // ****************************************
  // Flash timing
  // ****************************************
  localparam int CLK_MHZ          = 250;
  localparam int FLASH_HALF_MS    = 200;
  localparam int FLASH_HALF_CYC   = FLASH_HALF_MS * 1000 * CLK_MHZ;
  localparam int PAUSE_HALVES     = 4;
  localparam int RUN_HALF_MS      = 250;
  localparam int RUN_HALF_CYC     = RUN_HALF_MS * 1000 * CLK_MHZ;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SU_WAIT_PRM,
    SU_WAIT_CFG,
    SU_DATA_EX
  } startup_e;

  typedef enum logic [2:0] {
    FL_IDLE,
    FL_CODE,
    FL_PAUSE,
    FL_ARG,
    FL_GAP
  } flash_e;

  typedef struct packed {
    logic chksum_fail;
    logic code_overflow;
    logic unknown_dtype;
    logic cmd_fail;
    logic data_break;
    logic emc_fault;
    logic cycle_overrun;
  } tb_faults_s;

  typedef struct packed {
    logic        req;
    logic [15:0] index_group;
    logic [31:0] index_offset;
  } read_req_s;

endpackage
`default_nettype wire

// *** tb/diag_sva.sv ***
// Purpose: Port assertions for the diagnostics block
// Assumes: One clock, async active-low reset
// Notes:   Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module diag_sva
  import diag_pkg::*;
(
  // Clock, reset and inputs
  input wire logic       core_clk_in,
  input wire logic       reset_n_in,
  input wire logic       master_present_in,
  input wire logic       link_lost_in,
  input wire logic       tb_cycling_in,
  input wire logic       tb_retrig_in,
  input wire tb_faults_s tb_faults_in,
  input wire read_req_s  rd_req_in,
  // Outputs
  input wire logic       rd_valid_out,
  input wire logic [7:0] rd_data_out,
  input wire logic [7:0] fieldbus_state_code_out,
  input wire logic [7:0] tb_state_out,
  input wire logic       tb_run_indicator_out,
  input wire logic       terminal_bus_error_indicator_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ****************************************
  // Assertions
  // ****************************************
  property p_rd_valid; rd_valid_out == $past(rd_req_in.req); endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read answer timing");
  property p_rd_fb;
    rd_req_in == {1'b1, RD_INDEX_GROUP, RD_OFS_FB_STATE}
      |=> rd_data_out == $past(fieldbus_state_code_out);
  endproperty
  a_rd_fb: assert property (p_rd_fb) else $error("state code read wrong");
  property p_rd_bad;
    rd_req_in.req && rd_req_in.index_group != RD_INDEX_GROUP |=> rd_data_out == RD_UNMAPPED;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not zero");
  property p_no_master; !master_present_in |=> fieldbus_state_code_out == FB_NO_MASTER; endproperty
  a_no_master: assert property (p_no_master) else $error("no master code");
  property p_link; master_present_in && link_lost_in |=> fieldbus_state_code_out == FB_WAIT_PRM;
  endproperty
  a_link: assert property (p_link) else $error("link loss code");
  property p_order;
    $changed(fieldbus_state_code_out) && fieldbus_state_code_out == FB_OK
      |-> $past(fieldbus_state_code_out) == FB_WAIT_CFG;
  endproperty
  a_order: assert property (p_order) else $error("start-up order");
  property p_retrig; tb_retrig_in |-> ##2 tb_state_out[TB_BIT_RETRIG]; endproperty
  a_retrig: assert property (p_retrig) else $error("retrigger bit");
  property p_err_bit; tb_faults_in != '0 |-> ##2 tb_state_out[TB_BIT_ERROR]; endproperty
  a_err_bit: assert property (p_err_bit) else $error("error bit");
  property p_spare; (tb_state_out & 8'hfa) == 8'h00; endproperty
  a_spare: assert property (p_spare) else $error("spare state bits");
  property p_run_off; !tb_cycling_in |=> !tb_run_indicator_out; endproperty
  a_run_off: assert property (p_run_off) else $error("run indicator on");
  c_fb_read: cover property (rd_req_in.index_offset == RD_OFS_FB_STATE && rd_req_in.req);
  c_ok: cover property (fieldbus_state_code_out == FB_OK);
  c_err: cover property ($rose(terminal_bus_error_indicator_out));
endmodule
bind fieldbus_terminal_bus_diagnostics diag_sva u_sva (.core_clk_in, .reset_n_in,
  .master_present_in, .link_lost_in, .tb_cycling_in, .tb_retrig_in, .tb_faults_in, .rd_req_in,
  .rd_valid_out, .rd_data_out, .fieldbus_state_code_out, .tb_state_out, .tb_run_indicator_out,
  .terminal_bus_error_indicator_out);
`default_nettype wire

// *** tb/diag_master_model.sv ***
// Purpose: Fieldbus master start-up model
// Assumes: Commands arrive as a rising go_in
// Notes:   bad_order_in swaps the two telegrams
`timescale 1ns/100ps
`default_nettype none
module diag_master_model (
  // Clock and commands
  input  wire logic core_clk_in,
  input  wire logic go_in,
  input  wire logic bad_order_in,
  // Start-up events
  output logic      present_out,
  output logic      prm_out,
  output logic      cfg_out
);
  initial begin
    present_out = 1'b0;
    prm_out = 1'b0;
    cfg_out = 1'b0;
    forever begin
      @(posedge go_in);
      @(negedge core_clk_in);
      present_out = 1'b1;
      repeat (2) @(negedge core_clk_in);
      // Parameters, then configuration; configuration first when bad_order_in is set
      prm_out = !bad_order_in;
      cfg_out = bad_order_in;
      @(negedge core_clk_in);
      prm_out = bad_order_in;
      cfg_out = !bad_order_in;
      @(negedge core_clk_in);
      prm_out = 1'b0;
      cfg_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_fieldbus_terminal_bus_diagnostics.sv ***
// Purpose: Self-checking bench for the diagnostics block
// Assumes: Short flash parameters
// Notes:   Read results checked through a queue
`timescale 1ns/100ps
`default_nettype none
module tb_fieldbus_terminal_bus_diagnostics;
  import diag_pkg::*;
  localparam int H = 4;
  logic       core_clk_in, reset_n_in, master_present_in, link_lost_in;
  logic       prm_accepted_in, cfg_accepted_in, tb_cycling_in, tb_retrig_in, tb_ack_in;
  logic       rd_valid_out, tb_run_indicator_out, terminal_bus_error_indicator_out, go, bad;
  logic [7:0] rd_data_out, fieldbus_state_code_out, tb_state_out;
  tb_faults_s tb_faults_in;
  read_req_s  rd_req_in;
  logic [7:0] exp_q[$];
  logic [6:0] ft[7] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h41};
  int         ec[7] = '{1, 1, 1, 3, 4, 0, 7};
  int         ea[7] = '{0, 1, 2, 0, 0, 0, 0};
  int         seed, checks, miscompares;
  fieldbus_terminal_bus_diagnostics #(.FLASH_HALF(H), .RUN_HALF(H)) DUT (.core_clk_in,
    .reset_n_in, .master_present_in, .link_lost_in, .prm_accepted_in, .cfg_accepted_in,
    .tb_cycling_in, .tb_retrig_in, .tb_ack_in, .tb_faults_in, .rd_req_in, .rd_valid_out,
    .rd_data_out, .fieldbus_state_code_out, .tb_state_out, .tb_run_indicator_out,
    .terminal_bus_error_indicator_out);
  diag_master_model PM (.core_clk_in, .go_in(go), .bad_order_in(bad),
    .present_out(master_present_in), .prm_out(prm_accepted_in), .cfg_out(cfg_accepted_in));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] g, input logic [31:0] o, input logic [7:0] e);
    @(negedge core_clk_in);
    rd_req_in = {1'b1, g, o};
    exp_q.push_back(e);
  endtask
  task automatic idle(input int n);
    @(negedge core_clk_in);
    rd_req_in.req = 1'b0;
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic flashes(input tb_faults_s f, input int c, input int a);
    int n;
    logic p;
    n = 0;
    @(negedge core_clk_in);
    tb_faults_in = f;
    repeat (3 * H * (8 + 2 * c + 2 * a)) @(negedge core_clk_in);
    p = terminal_bus_error_indicator_out;
    repeat (H * (8 + 2 * c + 2 * a)) begin
      @(negedge core_clk_in);
      n += (terminal_bus_error_indicator_out === 1'b1 && p === 1'b0);
      p = terminal_bus_error_indicator_out;
    end
    cmp(8'(n), 8'(c + a));
  endtask
  task automatic do_reset();
    reset_n_in = 1'b0;
    repeat (12) @(negedge core_clk_in);
    reset_n_in = 1'b1;
  endtask
  task automatic start(input logic b);
    bad = b;
    go = 1'b1;
    idle(6);
    go = 1'b0;
  endtask
  // ****************************************
  // Clock, monitor and watchdog
  // ****************************************
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(negedge core_clk_in) begin
    if (rd_valid_out === 1'b1) begin
      cmp(rd_data_out, exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx);
    end
  end
  initial begin
    repeat (100000) @(posedge core_clk_in);
    miscompares++;
    summarize();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 91;
    {link_lost_in, tb_retrig_in, tb_ack_in, go, bad} = '0;
    tb_cycling_in = 1'b1;
    tb_faults_in = '0;
    rd_req_in = '0;
    do_reset();
    rd(RD_INDEX_GROUP, RD_OFS_FB_STATE, FB_NO_MASTER);
    rd(16'h0007, RD_OFS_FB_STATE, RD_UNMAPPED);
    repeat (4) rd(RD_INDEX_GROUP, $random(seed) | 32'h8000_0000, RD_UNMAPPED);
    idle(2);
    cmp({7'h00, tb_run_indicator_out}, 8'h01);
    tb_cycling_in = 1'b0;
    idle(2);
    cmp({7'h00, tb_run_indicator_out}, 8'h00);
    tb_cycling_in = 1'b1;
    start(1'b1);
    rd(RD_INDEX_GROUP, RD_OFS_FB_STATE, FB_WAIT_CFG);
    start(1'b0);
    rd(RD_INDEX_GROUP, RD_OFS_FB_STATE, FB_OK);
    link_lost_in = 1'b1;
    idle(1);
    cmp(fieldbus_state_code_out, FB_WAIT_PRM);
    link_lost_in = 1'b0;
    rd(RD_INDEX_GROUP, RD_OFS_FB_STATE, FB_WAIT_PRM);
    start(1'b0);
    rd(RD_INDEX_GROUP, RD_OFS_FB_STATE, FB_OK);
    tb_retrig_in = 1'b1;
    idle(0);
    tb_retrig_in = 1'b0;
    idle(3);
    cmp(tb_state_out, 8'h04);
    rd(RD_INDEX_GROUP, RD_OFS_TB_STATE, 8'h04);
    tb_faults_in = 7'h08;
    idle(3);
    rd(RD_INDEX_GROUP, RD_OFS_TB_STATE, 8'h05);
    tb_ack_in = 1'b1;
    idle(0);
    tb_ack_in = 1'b0;
    tb_faults_in = '0;
    idle(3);
    rd(RD_INDEX_GROUP, RD_OFS_TB_STATE, 8'h00);
    idle(2);
    for (int i = 0; i < 7; i++) flashes(ft[i], ec[i], ea[i]);
    flashes(7'h00, 7, 0);
    do_reset();
    flashes(7'h00, 0, 0);
    rd(RD_INDEX_GROUP, RD_OFS_FB_STATE, FB_WAIT_PRM);
    idle(3);
    if (exp_q.size() != 0) miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
